/* File: bmac_pkg.sv */
package bmac_pkg;

  // Command codes of the two word registers and of the rate register
  localparam logic [7:0]  CMD_TIME_THRESH   = 8'h02;
  localparam logic [7:0]  CMD_MODE_WORD     = 8'h03;
  localparam logic [7:0]  CMD_RATE          = 8'h04;

  // Mode word field positions
  localparam int          BIT_RELEARN       = 7;
  localparam int          BIT_ALARM_OFF     = 13;
  localparam int          BIT_CHARGE_OFF    = 14;
  localparam int          BIT_POWER_UNITS   = 15;

  // Reset values
  localparam logic [15:0] THRESH_RESET      = 16'h0000;
  localparam logic        RELEARN_RESET     = 1'b1;

  // Time base
  localparam int          REF_CLK_HZ        = 100_000_000;
  localparam int          TICK_PERIOD_S     = 1;
  localparam int          CYCLES_PER_TICK   = REF_CLK_HZ * TICK_PERIOD_S;

  // Broadcast inhibit lifetime: 60 ticks of a free-running second gives 59 to 60 s
  localparam int          INHIBIT_TIMEOUT_S = 60;
  localparam int          INHIBIT_TICKS     = INHIBIT_TIMEOUT_S / TICK_PERIOD_S;

  // Least spacing of alarm broadcasts; one extra tick covers the unknown tick phase
  localparam int          BCAST_SPACING_S   = 10;
  localparam int          SPACING_TICKS     = BCAST_SPACING_S / TICK_PERIOD_S + 1;

  // Cycle counts without a full-capacity update before relearn is requested
  localparam int          RELEARN_CYCLES    = 20;
  localparam int          TIMER_W           = 8;

endpackage

/* File: bmac_sec_tick.sv */
`timescale 1ns/10ps
module bmac_sec_tick #(
  parameter int CYCLES = bmac_pkg::CYCLES_PER_TICK
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // One-cycle tick once per period
  output logic      tick_o
);

  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [W-1:0] cnt_r;
  logic         tick_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (cnt_r == W'(CYCLES - 1))
    begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick_o = tick_r;

endmodule

/* File: bmac_sec_timer.sv */
`timescale 1ns/10ps
module bmac_sec_timer #(
  parameter int TICKS = 10,
  parameter int W     = bmac_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic start_i,
  input  wire logic stop_i,
  input  wire logic tick_i,
  // Status
  output logic      busy_o,
  output logic      expire_o
);

  logic [W-1:0] cnt_r;
  logic         expire_r;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      cnt_r <= '0;
    else if (start_i)
      cnt_r <= W'(TICKS);
    else if (stop_i)
      cnt_r <= '0;
    else if (tick_i && cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      expire_r <= 1'b0;
    else
      expire_r <= tick_i && (cnt_r == W'(1)) && !start_i && !stop_i;
  end

  assign busy_o   = (cnt_r != '0);
  assign expire_o = expire_r;

endmodule

/* File: bmac_mode_alarm.sv */
`timescale 1ns/10ps
// What this block does
// R1: Flag time alarm and request broadcast when averaged time-to-empty falls below threshold.
// R2: A zero threshold disables the time alarm.
// R3: Threshold loads from stored configuration at init and holds until host writes.
// R4: Threshold is a full-range unsigned 16-bit minutes word, read and written as word.
// R5: Mode word upper byte is writable, lower byte is read-only.
// R6: Mode bits 0 to 6 read zero and writes to bit 7 are ignored.
// R7: Relearn bit sets on full reset or 20 cycles without update; clears on learn.
// R8: Mode bits 8 to 12 have no function and read zero.
// R9: While alarm-off bit is set, no alarm broadcast and no bus mastering.
// R10: Each mode write restarts a 60 s timer whose expiry clears the alarm-off bit.
// R11: Host must rewrite alarm-off at least every 59 s to keep broadcasts off.
// R12: Successive alarm broadcasts are at least 10 s apart.
// R13: With alarm-off clear, any alarm condition causes a broadcast to host and charger.
// R14: Sleep entry clears alarm-off, charge-off and power-units bits.
// R15: Alarm-off bit never affects charge-off bit or charging broadcasts.
// R16: Charge-off bit set stops charging current and voltage broadcasts.
// R17: Power-units bit selects 10 mW/10 mWh reporting, clear selects mA/mAh.
// R18: Capacity values and dependent time and status values follow the unit selection.
// R19: Unit change refreshes non-rate values now, rate values at rate write or tick.
// R20: Inhibit timer runs from internal time base and is idle after reset.
module bmac_mode_alarm #(
  parameter int CYCLES_PER_TICK = bmac_pkg::CYCLES_PER_TICK
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Command port from the SMBus transaction layer
  input  wire logic        cmd_valid_i,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             cmd_hit_o,
  output logic             rd_valid_o,
  output logic [15:0]      rd_data_o,
  // Stored configuration
  input  wire logic        cfg_load_i,
  input  wire logic [15:0] cfg_thresh_i,
  // Gauge events
  input  wire logic [15:0] avg_tte_i,
  input  wire logic        full_reset_i,
  input  wire logic        cycle_count_inc_i,
  input  wire logic        fcc_update_i,
  input  wire logic        learn_done_i,
  input  wire logic        sleep_enter_i,
  input  wire logic        other_alarm_i,
  // Broadcast control
  output logic             alarm_req_o,
  output logic             time_alarm_flag_o,
  output logic             bus_master_en_o,
  output logic             charge_bcast_en_o,
  // Unit selection
  output logic             power_units_o,
  output logic             units_changed_o,
  output logic             rate_refresh_o
);

  function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] target);
    is_cmd = (code == target);
  endfunction

  logic [15:0] thresh_r;
  logic        relearn_r;
  logic        alarm_off_r;
  logic        charge_off_r;
  logic        power_units_r;
  logic [4:0]  cyc_cnt_r;
  logic        time_alarm_r;
  logic        rd_valid_r;
  logic [15:0] rd_data_r;
  logic        units_changed_r;
  logic        rate_pend_r;
  logic        rate_refresh_r;
  logic        tick;
  logic        inhibit_busy;
  logic        inhibit_expire;
  logic        holdoff_busy;
  logic        wr_thresh;
  logic        wr_mode;
  logic        wr_rate;
  logic        send;
  logic [15:0] mode_word;
  logic        power_units_nxt;

  assign wr_thresh = cmd_valid_i && cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_TIME_THRESH);
  assign wr_mode   = cmd_valid_i && cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_MODE_WORD);
  assign wr_rate   = cmd_valid_i && cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_RATE);
  assign cmd_hit_o = cmd_valid_i && (is_cmd(cmd_code_i, bmac_pkg::CMD_TIME_THRESH)
                                  || is_cmd(cmd_code_i, bmac_pkg::CMD_MODE_WORD));

  // Time base and timers
  bmac_sec_tick #(
    .CYCLES (CYCLES_PER_TICK)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick)
  );

  bmac_sec_timer #(
    .TICKS (bmac_pkg::INHIBIT_TICKS)
  ) u_inhibit (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (wr_mode && !sleep_enter_i),
    .stop_i    (sleep_enter_i),
    .tick_i    (tick),
    .busy_o    (inhibit_busy),
    .expire_o  (inhibit_expire)
  ); // R10 R14 R20

  bmac_sec_timer #(
    .TICKS (bmac_pkg::SPACING_TICKS)
  ) u_holdoff (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (send),
    .stop_i    (1'b0),
    .tick_i    (tick),
    .busy_o    (holdoff_busy),
    .expire_o  ()
  ); // R12

  // Remaining-time threshold
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      thresh_r <= bmac_pkg::THRESH_RESET;
    else if (wr_thresh)
      thresh_r <= cmd_wdata_i; // R4
    else if (cfg_load_i)
      thresh_r <= cfg_thresh_i; // R3
  end

  // Time alarm condition
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      time_alarm_r <= 1'b0;
    else
      time_alarm_r <= (thresh_r != 16'h0000) && (avg_tte_i < thresh_r); // R1 R2
  end

  // Relearn request
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      cyc_cnt_r <= '0;
    else if (fcc_update_i || full_reset_i)
      cyc_cnt_r <= '0;
    else if (cycle_count_inc_i)
    begin
      if (cyc_cnt_r == 5'(bmac_pkg::RELEARN_CYCLES - 1))
        cyc_cnt_r <= '0;
      else
        cyc_cnt_r <= cyc_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      relearn_r <= bmac_pkg::RELEARN_RESET; // R7
    else if (full_reset_i || (cycle_count_inc_i && !fcc_update_i
             && cyc_cnt_r == 5'(bmac_pkg::RELEARN_CYCLES - 1)))
      relearn_r <= 1'b1; // R7
    else if (learn_done_i)
      relearn_r <= 1'b0; // R7
  end

  // Writable mode bits; sleep wins over a write in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      alarm_off_r <= 1'b0;
    else if (sleep_enter_i)
      alarm_off_r <= 1'b0; // R14
    else if (wr_mode)
      alarm_off_r <= cmd_wdata_i[bmac_pkg::BIT_ALARM_OFF]; // R5
    else if (inhibit_expire)
      alarm_off_r <= 1'b0; // R10
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      charge_off_r <= 1'b0;
    else if (sleep_enter_i)
      charge_off_r <= 1'b0; // R14
    else if (wr_mode)
      charge_off_r <= cmd_wdata_i[bmac_pkg::BIT_CHARGE_OFF]; // R5 R15
  end

  always_comb
  begin
    power_units_nxt = power_units_r;
    if (sleep_enter_i)
      power_units_nxt = 1'b0; // R14
    else if (wr_mode)
      power_units_nxt = cmd_wdata_i[bmac_pkg::BIT_POWER_UNITS]; // R5
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      power_units_r <= 1'b0;
    else
      power_units_r <= power_units_nxt;
  end

  // Unit change refresh requests
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      units_changed_r <= 1'b0;
    else
      units_changed_r <= (power_units_nxt != power_units_r); // R19
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rate_pend_r <= 1'b0;
    else if (power_units_nxt != power_units_r)
      rate_pend_r <= 1'b1; // R19
    else if (wr_rate || tick)
      rate_pend_r <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rate_refresh_r <= 1'b0;
    else
      rate_refresh_r <= rate_pend_r && (wr_rate || tick); // R19
  end

  // Mode word assembly; bits 0-6 and 8-12 read zero
  always_comb
  begin
    mode_word                            = 16'h0000; // R6 R8
    mode_word[bmac_pkg::BIT_RELEARN]     = relearn_r;
    mode_word[bmac_pkg::BIT_ALARM_OFF]   = alarm_off_r;
    mode_word[bmac_pkg::BIT_CHARGE_OFF]  = charge_off_r;
    mode_word[bmac_pkg::BIT_POWER_UNITS] = power_units_r;
  end

  // Word reads answer one cycle later
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= 16'h0000;
    end
    else if (cmd_valid_i && !cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_TIME_THRESH))
    begin
      rd_valid_r <= 1'b1;
      rd_data_r  <= thresh_r; // R4
    end
    else if (cmd_valid_i && !cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_MODE_WORD))
    begin
      rd_valid_r <= 1'b1;
      rd_data_r  <= mode_word;
    end
    else
      rd_valid_r <= 1'b0;
  end

  // Alarm broadcast to host and charger
  assign send = (time_alarm_r || other_alarm_i) && !alarm_off_r && !holdoff_busy; // R9 R12 R13

  assign alarm_req_o       = send;
  assign time_alarm_flag_o = time_alarm_r; // R1
  assign bus_master_en_o   = !alarm_off_r; // R9
  assign charge_bcast_en_o = !charge_off_r; // R16
  assign power_units_o     = power_units_r; // R17 R18
  assign units_changed_o   = units_changed_r;
  assign rate_refresh_o    = rate_refresh_r;
  assign rd_valid_o        = rd_valid_r;
  assign rd_data_o         = rd_data_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_TIME_ALARM_SET: assert property ( // R1
    (thresh_r != 16'h0000 && avg_tte_i < thresh_r) |=> time_alarm_flag_o)
    else $error("time alarm flag not set below threshold");

  AST_ZERO_THRESH: assert property ( // R2
    (thresh_r == 16'h0000) |=> !time_alarm_flag_o)
    else $error("time alarm raised with zero threshold");

  AST_CFG_LOAD: assert property ( // R3
    (cfg_load_i && !wr_thresh) |=> (thresh_r == $past(cfg_thresh_i)))
    else $error("threshold not loaded from configuration");

  AST_THRESH_RW: assert property ( // R4
    (wr_thresh ##1 (!cmd_valid_i && !cfg_load_i)
      ##1 (cmd_valid_i && !cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_TIME_THRESH)))
      |=> (rd_valid_o && rd_data_o == $past(cmd_wdata_i, 3)))
    else $error("threshold read back differs from write");

  AST_MODE_ZERO_BITS: assert property ( // R6
    (cmd_valid_i && !cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_MODE_WORD))
      |=> (rd_valid_o && rd_data_o[6:0] == 7'h00 && rd_data_o[7] == $past(relearn_r)))
    else $error("mode word low bits wrong");

  AST_RESERVED_ZERO: assert property ( // R8
    (cmd_valid_i && !cmd_write_i && is_cmd(cmd_code_i, bmac_pkg::CMD_MODE_WORD))
      |=> (rd_data_o[12:8] == 5'h00))
    else $error("mode word reserved bits not zero");

  AST_RELEARN_SET: assert property ( // R7
    full_reset_i |=> relearn_r [*1] ##0 (mode_word[bmac_pkg::BIT_RELEARN]))
    else $error("relearn not set after full reset");

  AST_NO_BCAST_OFF: assert property ( // R9
    alarm_off_r |-> !alarm_req_o)
    else $error("alarm broadcast while alarm-off set");

  AST_SPACING: assert property ( // R12
    alarm_req_o |=> holdoff_busy && !alarm_req_o)
    else $error("alarm broadcasts not spaced");

  AST_EXPIRE_CLEAR: assert property ( // R10
    (inhibit_expire && !wr_mode && !sleep_enter_i) |=> !alarm_off_r)
    else $error("alarm-off not cleared at timer expiry");

  AST_SLEEP_CLEAR: assert property ( // R14
    sleep_enter_i |=> (mode_word[15:13] == 3'h0) && !inhibit_busy)
    else $error("sleep did not clear mode bits");

  AST_CHARGE_INDEP: assert property ( // R15
    (!wr_mode && !sleep_enter_i) |=> $stable(charge_off_r))
    else $error("charge-off changed without write or sleep");

  AST_UNITS_REFRESH: assert property ( // R19
    $changed(power_units_r) |-> units_changed_o ##1 (rate_pend_r || rate_refresh_o))
    else $error("unit change refresh missing");

  COV_ALARM_SENT: cover property (time_alarm_r && alarm_req_o);
  COV_INHIBIT_EXPIRE: cover property (alarm_off_r ##1 inhibit_expire ##1 !alarm_off_r);
  COV_RATE_REFRESH: cover property (units_changed_o ##[1:20] rate_refresh_o);

endmodule

/* File: bmac_host_model.sv */
`timescale 1ns/10ps
module bmac_host_model (
  // Clock
  input  wire logic        ref_clk_i,
  // Command port toward the gauge
  output logic             cmd_valid_o,
  output logic             cmd_write_o,
  output logic [7:0]       cmd_code_o,
  output logic [15:0]      cmd_wdata_o,
  input  wire logic        cmd_hit_i,
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  // Alarm broadcast seen by host and charger
  input  wire logic        alarm_req_i
);
  int alarms = 0;

  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 16'h0000;
  end

  always @(posedge ref_clk_i)
    if (alarm_req_i === 1'b1)
      alarms <= alarms + 1;

  // One word per call; a host keeping alarms off calls this at least every 59 s
  task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] wd,
                      output logic hit, output logic rv, output logic [15:0] rd);
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = w;
    cmd_code_o  = code;
    cmd_wdata_o = wd;
    #1;
    hit = cmd_hit_i;
    @(negedge ref_clk_i);
    rv = rd_valid_i;
    rd = rd_data_i;
    // Released lines show garbage, never the last word
    cmd_valid_o = 1'b0;
    cmd_write_o = ~w;
    cmd_code_o  = ~code;
    cmd_wdata_o = ~wd;
  endtask
endmodule

/* File: bmac_mode_alarm_tb.sv */
`timescale 1ns/10ps
module bmac_mode_alarm_tb;
  localparam int CPT = 10;
  logic        ref_clk_i, rst_n_i, cmd_valid_i, cmd_write_i, cmd_hit_o, rd_valid_o;
  logic [7:0]  cmd_code_i;
  logic [15:0] cmd_wdata_i, rd_data_o, cfg_thresh_i, avg_tte_i, rd, v;
  logic        cfg_load_i, full_reset_i, cycle_count_inc_i, fcc_update_i, learn_done_i;
  logic        sleep_enter_i, other_alarm_i, alarm_req_o, time_alarm_flag_o;
  logic        bus_master_en_o, charge_bcast_en_o, power_units_o, units_changed_o;
  logic        rate_refresh_o, hit, rv;
  int          miscompares, comparisons, seed, k, n, n_uc = 0, n_rr = 0;

  bmac_mode_alarm #(.CYCLES_PER_TICK(CPT)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
    .cmd_hit_o(cmd_hit_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .cfg_load_i(cfg_load_i), .cfg_thresh_i(cfg_thresh_i), .avg_tte_i(avg_tte_i),
    .full_reset_i(full_reset_i), .cycle_count_inc_i(cycle_count_inc_i),
    .fcc_update_i(fcc_update_i), .learn_done_i(learn_done_i),
    .sleep_enter_i(sleep_enter_i), .other_alarm_i(other_alarm_i),
    .alarm_req_o(alarm_req_o), .time_alarm_flag_o(time_alarm_flag_o),
    .bus_master_en_o(bus_master_en_o), .charge_bcast_en_o(charge_bcast_en_o),
    .power_units_o(power_units_o), .units_changed_o(units_changed_o),
    .rate_refresh_o(rate_refresh_o));

  bmac_host_model host_u (
    .ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
    .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i), .cmd_hit_i(cmd_hit_o),
    .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o), .alarm_req_i(alarm_req_o));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    if (units_changed_o === 1'b1)
      n_uc <= n_uc + 1;
    if (rate_refresh_o === 1'b1)
      n_rr <= n_rr + 1;
  end

  task automatic close_out;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      miscompares++;
    end
  endtask

  task automatic rd_word(input logic [7:0] code, output logic [15:0] d);
    host_u.xfer(1'b0, code, 16'h0000, hit, rv, d);
    chk({14'h0000, hit, rv}, 16'h0003, "read answer");
  endtask

  task automatic wr_word(input logic [7:0] code, input logic [15:0] d);
    host_u.xfer(1'b1, code, d, hit, rv, rd);
  endtask

  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask

  function automatic logic [15:0] mode_exp(input logic [15:0] w, input logic rl);
    return {w[15:13], 5'h00, rl, 7'h00};
  endfunction

  function automatic logic [15:0] ctl(input logic bm, input logic cb, input logic pu);
    return {13'h0000, bm, cb, pu};
  endfunction

  initial
  begin
    seed = 4786;
    miscompares = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    {cfg_load_i, full_reset_i, cycle_count_inc_i, fcc_update_i} = 4'h0;
    {learn_done_i, sleep_enter_i, other_alarm_i} = 3'h0;
    cfg_thresh_i = 16'h0000;
    avg_tte_i = 16'hffff;
    idle(2);
    rst_n_i = 1'b1;
    rd_word(bmac_pkg::CMD_TIME_THRESH, rd);
    chk(rd, bmac_pkg::THRESH_RESET, "threshold reset");
    rd_word(bmac_pkg::CMD_MODE_WORD, rd);
    chk(rd, 16'h0080, "mode reset");
    chk(ctl(bus_master_en_o, charge_bcast_en_o, power_units_o), 16'h0006, "ctl reset");
    $display("test reset done");

    v = 16'($random(seed));
    cfg_thresh_i = v;
    pulse(cfg_load_i);
    cfg_thresh_i = ~v;
    rd_word(bmac_pkg::CMD_TIME_THRESH, rd);
    chk(rd, v, "threshold from config");
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 16'hffff : 16'($random(seed));
      wr_word(bmac_pkg::CMD_TIME_THRESH, v);
      rd_word(bmac_pkg::CMD_TIME_THRESH, rd);
      chk(rd, v, "threshold word");
    end
    $display("test threshold done");

    for (int i = 0; i < 5; i++)
    begin
      v = (i == 0) ? 16'hffff : 16'($random(seed));
      wr_word(bmac_pkg::CMD_MODE_WORD, v);
      rd_word(bmac_pkg::CMD_MODE_WORD, rd);
      chk(rd, mode_exp(v, 1'b1), "mode word");
      chk(ctl(bus_master_en_o, charge_bcast_en_o, power_units_o),
          ctl(~v[13], ~v[14], v[15]), "mode controls");
    end
    wr_word(bmac_pkg::CMD_MODE_WORD, 16'h0000);
    idle(12);
    n = n_uc;
    k = n_rr;
    wr_word(bmac_pkg::CMD_MODE_WORD, 16'h8000);
    idle(3);
    chk(16'(n_uc - n), 16'h0001, "units change pulse");
    wr_word(bmac_pkg::CMD_RATE, 16'($random(seed)));
    idle(12);
    chk(16'(n_rr - k), 16'h0001, "rate refresh");
    host_u.xfer(1'b0, 8'h05, 16'h0000, hit, rv, rd);
    chk({14'h0000, hit, rv}, 16'h0000, "unmapped code");
    $display("test mode word done");

    wr_word(bmac_pkg::CMD_MODE_WORD, 16'he000);
    pulse(sleep_enter_i);
    rd_word(bmac_pkg::CMD_MODE_WORD, rd);
    chk(rd, 16'h0080, "sleep clears");
    chk(ctl(bus_master_en_o, charge_bcast_en_o, power_units_o), 16'h0006, "sleep ctl");
    pulse(learn_done_i);
    rd_word(bmac_pkg::CMD_MODE_WORD, rd);
    chk(rd, 16'h0000, "relearn cleared");
    repeat (19) pulse(cycle_count_inc_i);
    pulse(fcc_update_i);
    repeat (19) pulse(cycle_count_inc_i);
    rd_word(bmac_pkg::CMD_MODE_WORD, rd);
    chk(rd, 16'h0000, "relearn early");
    pulse(cycle_count_inc_i);
    rd_word(bmac_pkg::CMD_MODE_WORD, rd);
    chk(rd, 16'h0080, "relearn on count");
    pulse(learn_done_i);
    pulse(full_reset_i);
    rd_word(bmac_pkg::CMD_MODE_WORD, rd);
    chk(rd, 16'h0080, "relearn on full reset");
    $display("test sleep and relearn done");

    wr_word(bmac_pkg::CMD_MODE_WORD, 16'h2000);
    chk(ctl(bus_master_en_o, charge_bcast_en_o, 1'b0), 16'h0002, "alarm off only");
    n = host_u.alarms;
    wr_word(bmac_pkg::CMD_TIME_THRESH, 16'h0064);
    avg_tte_i = 16'({$random(seed)} % 100);
    idle(400);
    chk(16'(host_u.alarms - n), 16'h0000, "alarm while off");
    wr_word(bmac_pkg::CMD_MODE_WORD, 16'h2000);
    idle(575);
    chk({15'h0000, bus_master_en_o}, 16'h0000, "inhibit early end");
    for (k = 0; k < 40 && bus_master_en_o !== 1'b1; k++)
      idle(1);
    chk({15'h0000, bus_master_en_o}, 16'h0001, "inhibit expiry");
    if (k == 40)
      close_out();
    idle(2);
    chk(16'(host_u.alarms - n), 16'h0001, "time alarm sent");
    chk({15'h0000, time_alarm_flag_o}, 16'h0001, "time alarm flag");
    idle(95);
    chk(16'(host_u.alarms - n), 16'h0001, "alarm spacing");
    idle(30);
    chk(16'(host_u.alarms - n), 16'h0002, "alarm repeat");
    wr_word(bmac_pkg::CMD_TIME_THRESH, 16'h0000);
    idle(3);
    chk({15'h0000, time_alarm_flag_o}, 16'h0000, "zero threshold");
    n = host_u.alarms;
    idle(130);
    chk(16'(host_u.alarms - n), 16'h0000, "no alarm at zero");
    other_alarm_i = 1'b1;
    idle(120);
    other_alarm_i = 1'b0;
    chk({15'h0000, host_u.alarms > n}, 16'h0001, "other alarm sent");
    $display("test alarm done");
    close_out();
  end
endmodule
